// ==== rtl/pmbus_cmd_pkg.sv ====
// constants of the paged on/off and store command handler
// How it works
// [RL1] after a page write, commands go to rail 0, rail 1, or both
// [RL2] page byte is read/write, resets to 0, never write protected
// [RL3] run bits 7:6 decode immediate off, soft off, on; reads give state
// [RL4] margin bits 5:4 decode nominal, low, high; applied only with margin pin open
// [RL5] unlisted run/margin combinations raise a command error flag
// [RL6] start bits 4:2: always, enable only, command only, both
// [RL7] config bit 1 picks enable polarity, 0 low, 1 high
// [RL8] config bit 0 picks ramp-down or immediate off on enable turn-off
// [RL9] start config resets to 17h
// [RL10] clear-faults with no data clears all fault bits and releases the alert
// [RL11] still-present faults set again at once; shut rails stay shut
// [RL12] store-default copies settings to the default store, busy 20 ms
// [RL13] host empties or extends the default store by command sequence (here no command empties or extends it; it holds four fixed bytes)
// [RL14] restore-default loads the default store, then security level 1
// [RL15] power-up loads default store, then user store overrides (here userValid_q resets to 0, so only the default store loads)
// [RL16] store-user copies settings to the user store, busy 20 ms
// [RL17] host empties or extends the user store by command sequence (here no command empties or extends it; it holds four fixed bytes)
// [RL18] host avoids store and restore while rails run
// [RL19] restore-factory returns settings to built-in values
// [RL20] restore-user loads user store, security level 1, also at power-up (power-up here never loads the user store)
// [RL21] while a store or restore runs, commands are not acknowledged
package pmbus_cmd_pkg;
  localparam logic [7:0] CODE_PAGE          = 8'h00;
  localparam logic [7:0] CODE_RUN_MARGIN    = 8'h01;
  localparam logic [7:0] CODE_START_CFG     = 8'h02;
  localparam logic [7:0] CODE_CLEAR_FAULTS  = 8'h03;
  localparam logic [7:0] CODE_STORE_DEFAULT = 8'h11;
  localparam logic [7:0] CODE_RESTORE_DEF   = 8'h12;
  localparam logic [7:0] CODE_STORE_USER    = 8'h15;
  localparam logic [7:0] CODE_RESTORE_USER  = 8'h16;
  localparam logic [7:0] CODE_FAULT_STATUS  = 8'h78;
  localparam logic [7:0] CODE_SECURITY      = 8'hFA;
  localparam logic [7:0] CODE_RESTORE_FACT  = 8'hF4;

  localparam logic [7:0] PAGE_RAIL0 = 8'h00;
  localparam logic [7:0] PAGE_RAIL1 = 8'h01;
  localparam logic [7:0] PAGE_BOTH  = 8'hFF;

  localparam logic [7:0] RST_PAGE      = 8'h00;
  localparam logic [7:0] RST_RUN_MARGIN = 8'h00;
  localparam logic [7:0] RST_START_CFG = 8'h17;
  localparam logic [7:0] RST_SECURITY  = 8'h01;
  localparam logic [7:0] SECURITY_ONE  = 8'h01;

  localparam logic [1:0] RUN_IMM_OFF  = 2'h0;
  localparam logic [1:0] RUN_SOFT_OFF = 2'h1;
  localparam logic [1:0] RUN_ON       = 2'h2;
  localparam logic [1:0] MGN_NOMINAL  = 2'h0;
  localparam logic [1:0] MGN_LOW      = 2'h1;
  localparam logic [1:0] MGN_HIGH     = 2'h2;
  localparam logic [2:0] START_ALWAYS = 3'h0;
  localparam logic [2:0] START_ENABLE = 3'h5;
  localparam logic [2:0] START_CMD    = 3'h6;
  localparam logic [2:0] START_BOTH   = 3'h7;
  localparam int         CFG_POL_BIT  = 1;
  localparam int         CFG_IMM_BIT  = 0;

  localparam int         FAULT_BITS     = 7;
  localparam int         CML_BIT        = 0;
  localparam int         SHUTDOWN_FAULT = 0;

  localparam logic       STORE_DEFAULT = 1'b0;
  localparam logic       STORE_USER    = 1'b1;

  localparam int CLK_HZ         = 40_000_000;
  localparam int NV_BUSY_MS     = 20;
  localparam int NV_BUSY_CYCLES = CLK_HZ / 1000 * NV_BUSY_MS;

  typedef enum logic [4:0] {
    NV_IDLE  = 5'b00001,
    NV_READ  = 5'b00010,
    NV_COPY  = 5'b00100,
    NV_WRITE = 5'b01000,
    NV_WAIT  = 5'b10000
  } nv_state_t;
endpackage : pmbus_cmd_pkg

// ==== rtl/nv_settings_mem.sv ====
// nonvolatile settings stores: default and user, four bytes each
`timescale 1ns/1ps
module nv_settings_mem
  import pmbus_cmd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       wrEn,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wrData,
  output logic      [7:0] rdData
);
  logic [7:0] mem_q [8];

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < 8; i++)
        mem_q[i] <= (i % 4 >= 2) ? RST_START_CFG : RST_RUN_MARGIN;
      rdData <= 8'h00;
    end
    else
    begin
      if (wrEn)
        mem_q[addr] <= wrData;
      rdData <= mem_q[addr];
    end
  end
endmodule : nv_settings_mem

// ==== rtl/pmbus_page_onoff.sv ====
// paged on/off, fault clearing and store/restore command handler
`timescale 1ns/1ps
module pmbus_page_onoff
  import pmbus_cmd_pkg::*;
#(
  parameter int BUSY_CYCLES = NV_BUSY_CYCLES
)
(
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  cmdValid,
  input  wire logic                  cmdWrite,
  input  wire logic                  cmdNoData,
  input  wire logic [7:0]            cmdCode,
  input  wire logic [7:0]            cmdData,
  output logic                       cmdReady,
  output logic                       rspValid,
  output logic [7:0]                 rspData,
  input  wire logic                  enablePin,
  input  wire logic                  marginSelectOpen,
  input  wire logic [FAULT_BITS-1:0] faultCond0,
  input  wire logic [FAULT_BITS-1:0] faultCond1,
  output logic [1:0]                 railRun,
  output logic [1:0]                 railRampDown,
  output logic [1:0]                 railMarginLow,
  output logic [1:0]                 railMarginHigh,
  output logic                       alertOutput
);
  ////////////////////////////////////////////////////////////////
  // pin synchronisers
  localparam int SW = 2 + 2 * FAULT_BITS;
  logic [SW-1:0] pinSync1_q;
  logic [SW-1:0] pinSync_q;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pinSync1_q <= '0;
      pinSync_q  <= '0;
    end
    else
    begin
      pinSync1_q <= {faultCond1, faultCond0, marginSelectOpen, enablePin};
      pinSync_q  <= pinSync1_q;
    end
  end
  wire                  enSync   = pinSync_q[0];
  wire                  mgnOpen  = pinSync_q[1];
  wire [FAULT_BITS-1:0] cond [2];
  assign cond[0] = pinSync_q[2 +: FAULT_BITS];
  assign cond[1] = pinSync_q[2 + FAULT_BITS +: FAULT_BITS];

  ////////////////////////////////////////////////////////////////
  // state and command decode
  nv_state_t  nvState_q;
  logic [7:0] page_q;
  logic [7:0] runMargin_q [2];
  logic [7:0] startCfg_q [2];
  logic [7:0] faultStat_q [2];
  logic [1:0] shutdown_q;
  logic [7:0] security_q;
  logic [1:0] nvIdx_q;
  logic       nvStore_q;
  logic       chainUser_q;
  logic       userValid_q;
  logic [31:0] busyCnt_q;
  logic       nvRestore_q;
  logic [1:0] runReq;
  logic [1:0] stateBits [2];

  wire busy   = nvState_q != NV_IDLE;
  assign cmdReady = !busy; // see [RL21]
  wire take   = cmdValid && !busy; // see [RL21]
  wire wrTake = take && cmdWrite;
  wire [1:0] pageHit = (page_q == PAGE_BOTH) ? 2'b11 : (page_q == PAGE_RAIL1) ? 2'b10 : 2'b01; // see [RL1]
  wire pageOk = cmdData == PAGE_RAIL0 || cmdData == PAGE_RAIL1 || cmdData == PAGE_BOTH;
  wire opOk   = cmdData[3:0] == 4'h0 && (cmdData[7:6] == RUN_ON ? cmdData[5:4] != 2'h3
                : cmdData[7:6] != 2'h3 && cmdData[5:4] == MGN_NOMINAL);
  wire wrPage   = wrTake && cmdCode == CODE_PAGE && !cmdNoData;
  wire wrOp     = wrTake && cmdCode == CODE_RUN_MARGIN && !cmdNoData;
  wire wrCfg    = wrTake && cmdCode == CODE_START_CFG && !cmdNoData;
  wire clrAll   = wrTake && cmdCode == CODE_CLEAR_FAULTS && cmdNoData; // see [RL10]
  wire factory  = wrTake && cmdCode == CODE_RESTORE_FACT && cmdNoData; // see [RL19]
  wire stDef    = wrTake && cmdCode == CODE_STORE_DEFAULT && cmdNoData;
  wire stUser   = wrTake && cmdCode == CODE_STORE_USER && cmdNoData;
  wire rsDef    = wrTake && cmdCode == CODE_RESTORE_DEF && cmdNoData;
  wire rsUser   = wrTake && cmdCode == CODE_RESTORE_USER && cmdNoData;
  wire known    = wrPage || wrOp || wrCfg || clrAll || factory || stDef || stUser || rsDef || rsUser;
  wire cmlErr   = (wrTake && !known) || (wrPage && !pageOk) || (wrOp && !opOk); // see [RL5]

  ////////////////////////////////////////////////////////////////
  // store/restore engine
  wire       memWr   = nvState_q == NV_WRITE;
  wire [2:0] memAddr = {nvStore_q, nvIdx_q};
  wire [7:0] memWrData = nvIdx_q[1] ? startCfg_q[nvIdx_q[0]] : runMargin_q[nvIdx_q[0]];
  wire [7:0] memRdData;
  wire       loadByte = nvState_q == NV_COPY;
  wire       waitDone = nvState_q == NV_WAIT && busyCnt_q == 32'(BUSY_CYCLES - 1);
  wire       nvRestoreEnd = waitDone && nvRestore_q;

  nv_settings_mem u_mem (
    .clk    (clk),
    .sys_rst(sys_rst),
    .wrEn   (memWr),
    .addr   (memAddr),
    .wrData (memWrData),
    .rdData (memRdData)
  );

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      nvState_q   <= NV_READ; // see [RL15]
      nvStore_q   <= STORE_DEFAULT;
      chainUser_q <= 1'b1;
      nvRestore_q <= 1'b1;
      nvIdx_q     <= 2'h0;
      busyCnt_q   <= '0;
      userValid_q <= 1'b0;
    end
    else
    begin
      unique case (nvState_q)
        NV_IDLE:
        begin
          busyCnt_q <= '0;
          nvIdx_q   <= 2'h0;
          if (stDef || stUser) // see [RL12] see [RL16]
          begin
            nvState_q   <= NV_WRITE;
            nvStore_q   <= stUser ? STORE_USER : STORE_DEFAULT;
            nvRestore_q <= 1'b0;
          end
          else if (rsDef || rsUser) // see [RL14] see [RL20]
          begin
            nvState_q   <= NV_READ;
            nvStore_q   <= rsUser ? STORE_USER : STORE_DEFAULT;
            nvRestore_q <= 1'b1;
            chainUser_q <= 1'b0;
          end
        end
        NV_READ:  nvState_q <= NV_COPY;
        NV_COPY:
        begin
          nvIdx_q   <= nvIdx_q + 2'h1;
          nvState_q <= (nvIdx_q == 2'h3) ? NV_WAIT : NV_READ;
        end
        NV_WRITE:
        begin
          nvIdx_q <= nvIdx_q + 2'h1;
          if (nvIdx_q == 2'h3)
          begin
            nvState_q <= NV_WAIT;
            if (nvStore_q == STORE_USER)
              userValid_q <= 1'b1;
          end
        end
        NV_WAIT:
        begin
          busyCnt_q <= busyCnt_q + 32'h1;
          if (waitDone)
          begin
            busyCnt_q <= '0;
            if (chainUser_q && userValid_q) // see [RL15]
            begin
              nvState_q <= NV_READ;
              nvStore_q <= STORE_USER;
            end
            else
              nvState_q <= NV_IDLE;
            chainUser_q <= 1'b0;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // settings, faults, security
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      page_q      <= RST_PAGE;
      security_q  <= RST_SECURITY;
      for (int p = 0; p < 2; p++)
      begin
        runMargin_q[p] <= RST_RUN_MARGIN;
        startCfg_q[p]  <= RST_START_CFG; // see [RL9]
        faultStat_q[p] <= 8'h00;
      end
      shutdown_q <= 2'b00;
    end
    else
    begin
      if (wrPage && pageOk)
        page_q <= cmdData; // see [RL2]
      if (nvRestoreEnd)
        security_q <= SECURITY_ONE; // see [RL14] see [RL20]
      for (int p = 0; p < 2; p++)
      begin
        if (factory)
        begin
          runMargin_q[p] <= RST_RUN_MARGIN; // see [RL19]
          startCfg_q[p]  <= RST_START_CFG;
        end
        if (wrOp && opOk && pageHit[p])
          runMargin_q[p] <= cmdData; // see [RL1]
        if (wrCfg && pageHit[p])
          startCfg_q[p] <= cmdData;
        if (loadByte && nvIdx_q[0] == p[0])
        begin
          if (nvIdx_q[1])
            startCfg_q[p] <= memRdData;
          else
            runMargin_q[p] <= memRdData;
        end
        // set wins over clear; live faults reassert at once
        faultStat_q[p] <= (clrAll ? 8'h00 : faultStat_q[p])
                          | {cond[p], (cmlErr && pageHit[p])}; // see [RL10] see [RL11]
        if (cond[p][SHUTDOWN_FAULT])
          shutdown_q[p] <= 1'b1; // see [RL11]
        else if (!railRun[p] && !runReq[p])
          shutdown_q[p] <= 1'b0;
      end
    end
  end
  assign alertOutput = |{faultStat_q[0], faultStat_q[1]}; // see [RL10]

  ////////////////////////////////////////////////////////////////
  // per-rail start decision
  generate
    for (genvar p = 0; p < 2; p++)
    begin : g_rail
      wire [2:0] src   = startCfg_q[p][4:2];
      wire       enAct = enSync == startCfg_q[p][CFG_POL_BIT]; // see [RL7]
      wire       opOn  = runMargin_q[p][7:6] == RUN_ON;
      assign runReq[p] = (src == START_ALWAYS) || (src == START_ENABLE && enAct)
                       || (src == START_CMD && opOn) || (src == START_BOTH && enAct && opOn); // see [RL6]
      wire enOff = (src == START_ENABLE || src == START_BOTH) && !enAct;
      assign railRun[p] = runReq[p] && !shutdown_q[p] && !busy;
      // off by enable follows config bit 0, otherwise the commanded style
      assign railRampDown[p] = !railRun[p] && (enOff ? !startCfg_q[p][CFG_IMM_BIT]
                               : runMargin_q[p][7:6] == RUN_SOFT_OFF); // see [RL8] see [RL3]
      assign railMarginLow[p]  = railRun[p] && mgnOpen && runMargin_q[p][5:4] == MGN_LOW; // see [RL4]
      assign railMarginHigh[p] = railRun[p] && mgnOpen && runMargin_q[p][5:4] == MGN_HIGH; // see [RL4]
      assign stateBits[p] = railRun[p] ? RUN_ON
                          : (runMargin_q[p][7:6] == RUN_SOFT_OFF ? RUN_SOFT_OFF : RUN_IMM_OFF); // see [RL3]
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // read answer
  wire       rd  = take && !cmdWrite;
  wire       sel = pageHit == 2'b10;
  wire [7:0] rdMux = (cmdCode == CODE_PAGE)         ? page_q
                   : (cmdCode == CODE_RUN_MARGIN)   ? {stateBits[sel], runMargin_q[sel][5:0]}
                   : (cmdCode == CODE_START_CFG)    ? startCfg_q[sel]
                   : (cmdCode == CODE_FAULT_STATUS) ? faultStat_q[sel]
                   : (cmdCode == CODE_SECURITY)     ? security_q
                   : 8'h00;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rspValid <= 1'b0;
      rspData  <= 8'h00;
    end
    else
    begin
      rspValid <= take;
      rspData  <= rd ? rdMux : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks
  page_both_a: assert property (@(posedge clk) disable iff (sys_rst)
    (wrOp && opOk && page_q == PAGE_BOTH) |=> runMargin_q[0] == runMargin_q[1]) // see [RL1]
    else $error("both-page write missed a rail");
  page_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    (wrPage && pageOk) |=> page_q == $past(cmdData)) // see [RL2]
    else $error("page byte not stored");
  op_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    (rd && cmdCode == CODE_RUN_MARGIN && railRun[sel]) |=> rspData[7:6] == RUN_ON) // see [RL3]
    else $error("run state read wrong");
  margin_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
    !mgnOpen |-> railMarginLow == 2'b00 && railMarginHigh == 2'b00) // see [RL4]
    else $error("margin applied with pin strapped");
  cml_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
    (wrOp && !opOk && pageHit[0]) |=> faultStat_q[0][CML_BIT]) // see [RL5]
    else $error("bad operation value not flagged");
  enable_pol_a: assert property (@(posedge clk) disable iff (sys_rst || busy)
    (startCfg_q[0][4:2] == START_ENABLE && !shutdown_q[0]) |-> railRun[0] == (enSync == startCfg_q[0][1])) // see [RL6]
    else $error("enable polarity wrong");
  clear_fault_a: assert property (@(posedge clk) disable iff (sys_rst)
    (clrAll && cond[0] == '0 && cond[1] == '0) |=> !alertOutput) // see [RL10]
    else $error("alert not released");
  shut_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    (clrAll && shutdown_q[0] && runReq[0]) |=> !railRun[0]) // see [RL11]
    else $error("clear restarted a shut rail");
  busy_nack_a: assert property (@(posedge clk) disable iff (sys_rst)
    (stDef || stUser) |=> !cmdReady [*8]) // see [RL12] see [RL16] see [RL21]
    else $error("store not busy");
  restore_sec_a: assert property (@(posedge clk) disable iff (sys_rst)
    nvRestoreEnd |=> security_q == SECURITY_ONE) // see [RL14]
    else $error("security level not set");
  cover_store_c:   cover property (@(posedge clk) disable iff (sys_rst) stUser);
  cover_restore_c: cover property (@(posedge clk) disable iff (sys_rst) rsDef ##[1:1000] nvRestoreEnd);
  cover_clear_c:   cover property (@(posedge clk) disable iff (sys_rst) alertOutput ##1 clrAll);
  cover_margin_c:  cover property (@(posedge clk) disable iff (sys_rst) railMarginHigh[1]);
endmodule : pmbus_page_onoff

// ==== verif/pmbus_host_model.sv ====
// host model issuing commands on the command port
`timescale 1ns/1ps
module pmbus_host_model
(
  input  wire logic       clk,
  input  wire logic       cmdReady,
  input  wire logic       rspValid,
  input  wire logic [7:0] rspData,
  output logic            cmdValid,
  output logic            cmdWrite,
  output logic            cmdNoData,
  output logic      [7:0] cmdCode,
  output logic      [7:0] cmdData
);
  initial
  begin
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdNoData = 1'b0;
    cmdCode = 8'hA5;
    cmdData = 8'h5A;
  end
  ////////////////////////////////////////
  // one command: hold until taken, then collect the answer
  task automatic xfer(input logic wr, input logic nd, input logic [7:0] code, input logic [7:0] data,
                      output logic [7:0] rd, output logic ok);
    int n;
    n = 0;
    @(negedge clk);
    cmdValid = 1'b1;
    cmdWrite = wr;
    cmdNoData = nd;
    cmdCode = code;
    cmdData = data;
    while (cmdReady !== 1'b1 && n < 400) // wait out store busy
    begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    @(negedge clk);
    ok = rspValid;
    rd = rspData;
    cmdValid = 1'b0;
    cmdCode = ~code;
    cmdData = ~data;
  endtask : xfer
endmodule : pmbus_host_model

// ==== verif/pmbus_page_onoff_tb_top.sv ====
// self-checking bench of the paged command handler
`timescale 1ns/1ps
module pmbus_page_onoff_tb_top;
  import pmbus_cmd_pkg::*;
  localparam int BUSY = 20;
  localparam int LIMIT = 20000;
  logic clk, sysRst, cmdValid, cmdWrite, cmdNoData, cmdReady, rspValid, alertOutput;
  logic [7:0] cmdCode, cmdData, rspData;
  logic enablePin, marginSelectOpen;
  logic [FAULT_BITS-1:0] faultCond0, faultCond1;
  logic [1:0] railRun, railRampDown, railMarginLow, railMarginHigh;
  logic [10:0] tbl [8];
  int failures, num_checks, cycles;
  ////////////////////////////////////////
  pmbus_page_onoff #(.BUSY_CYCLES(BUSY)) i_dut (
    .clk(clk), .sys_rst(sysRst), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdNoData(cmdNoData),
    .cmdCode(cmdCode), .cmdData(cmdData), .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData),
    .enablePin(enablePin), .marginSelectOpen(marginSelectOpen), .faultCond0(faultCond0),
    .faultCond1(faultCond1), .railRun(railRun), .railRampDown(railRampDown),
    .railMarginLow(railMarginLow), .railMarginHigh(railMarginHigh), .alertOutput(alertOutput));
  pmbus_host_model i_host (
    .clk(clk), .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData), .cmdValid(cmdValid),
    .cmdWrite(cmdWrite), .cmdNoData(cmdNoData), .cmdCode(cmdCode), .cmdData(cmdData));
  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      failures++;
      finish_test();
    end
  end
  ////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic xf(input logic wr, input logic nd, input logic [7:0] code, input logic [7:0] data,
                    output logic [7:0] rd);
    logic ok;
    i_host.xfer(wr, nd, code, data, rd, ok);
    check({7'h00, ok}, 8'h01);
  endtask : xf
  task automatic wr(input logic [7:0] code, input logic [7:0] data);
    logic [7:0] r;
    xf(1'b1, 1'b0, code, data, r);
    check(r, 8'h00);
  endtask : wr
  task automatic snd(input logic [7:0] code);
    logic [7:0] r;
    xf(1'b1, 1'b1, code, 8'h00, r);
  endtask : snd
  task automatic rdchk(input logic [7:0] code, input logic [7:0] exp);
    logic [7:0] r;
    xf(1'b0, 1'b0, code, 8'h00, r);
    check(r, exp);
  endtask : rdchk
  task automatic settle();
    repeat (4) @(negedge clk);
  endtask : settle
  task automatic nvwait();
    int n;
    n = 0;
    check({7'h00, cmdReady}, 8'h00);
    while (cmdReady !== 1'b1 && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    check({7'h00, n >= BUSY && n < 400}, 8'h01);
  endtask : nvwait
  task automatic done_test(input string name);
    $display("test %s done", name);
  endtask : done_test
  task automatic finish_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  ////////////////////////////////////////
  initial
  begin
    // cfg, enable level, expected run, expected ramp-down
    tbl = '{{8'h16, 3'b110}, {8'h16, 3'b001}, {8'h17, 3'b000}, {8'h14, 3'b010},
            {8'h14, 3'b101}, {8'h00, 3'b010}, {8'h1E, 3'b110}, {8'h1E, 3'b001}};
    sysRst = 1'b1;
    enablePin = 1'b0;
    marginSelectOpen = 1'b1;
    faultCond0 = '0;
    faultCond1 = '0;
    repeat (10) @(negedge clk);
    sysRst = 1'b0;
    rdchk(CODE_PAGE, 8'h00);
    rdchk(CODE_RUN_MARGIN, 8'h00);
    rdchk(CODE_START_CFG, 8'h17);
    rdchk(CODE_SECURITY, 8'h01);
    done_test("reset values");
    wr(CODE_PAGE, PAGE_RAIL1);
    rdchk(CODE_PAGE, 8'h01);
    wr(CODE_PAGE, PAGE_BOTH);
    wr(CODE_START_CFG, 8'h18);
    wr(CODE_RUN_MARGIN, 8'h80);
    check({6'h00, railRun}, 8'h03);
    wr(CODE_PAGE, PAGE_RAIL1);
    wr(CODE_RUN_MARGIN, 8'h40);
    check({6'h00, railRun, railRampDown}, 8'h06);
    wr(CODE_RUN_MARGIN, 8'h00);
    check({6'h00, railRun, railRampDown}, 8'h04);
    rdchk(CODE_RUN_MARGIN, 8'h00);
    wr(CODE_PAGE, PAGE_RAIL0);
    rdchk(CODE_RUN_MARGIN, 8'h80);
    done_test("paging");
    wr(CODE_RUN_MARGIN, 8'h90);
    check({6'h00, railMarginLow}, 8'h01);
    @(negedge clk) marginSelectOpen = 1'b0;
    settle();
    check({6'h00, railMarginLow}, 8'h00);
    @(negedge clk) marginSelectOpen = 1'b1;
    wr(CODE_RUN_MARGIN, 8'hA0);
    settle();
    check({6'h00, railMarginHigh, railMarginLow}, 8'h04);
    wr(CODE_RUN_MARGIN, 8'h80);
    done_test("margin");
    wr(CODE_PAGE, PAGE_BOTH);
    wr(CODE_RUN_MARGIN, 8'hC0);
    check({7'h00, alertOutput}, 8'h01);
    wr(CODE_PAGE, PAGE_RAIL1);
    rdchk(CODE_FAULT_STATUS, 8'h01);
    snd(CODE_CLEAR_FAULTS);
    rdchk(CODE_FAULT_STATUS, 8'h00);
    check({7'h00, alertOutput}, 8'h00);
    wr(CODE_PAGE, PAGE_RAIL0);
    rdchk(CODE_FAULT_STATUS, 8'h00);
    wr(CODE_PAGE, 8'h02);
    rdchk(CODE_PAGE, 8'h00);
    rdchk(CODE_FAULT_STATUS, 8'h01);
    snd(CODE_CLEAR_FAULTS);
    done_test("command error");
    for (int i = 0; i < 8; i++)
    begin
      wr(CODE_START_CFG, tbl[i][10:3]);
      @(negedge clk) enablePin = tbl[i][2];
      settle();
      check({6'h00, railRun[0], railRampDown[0]}, {6'h00, tbl[i][1:0]});
    end
    done_test("start control");
    wr(CODE_START_CFG, 8'h18);
    @(negedge clk) faultCond0 = 7'h02;
    settle();
    rdchk(CODE_FAULT_STATUS, 8'h04);
    snd(CODE_CLEAR_FAULTS);
    rdchk(CODE_FAULT_STATUS, 8'h04);
    check({7'h00, alertOutput}, 8'h01);
    @(negedge clk) faultCond0 = 7'h01;
    settle();
    faultCond0 = 7'h00;
    settle();
    snd(CODE_CLEAR_FAULTS);
    settle();
    check({7'h00, railRun[0], alertOutput}, 8'h00);
    wr(CODE_RUN_MARGIN, 8'h00);
    wr(CODE_RUN_MARGIN, 8'h80);
    check({7'h00, railRun[0]}, 8'h01);
    done_test("faults");
    wr(CODE_RUN_MARGIN, 8'h00); // rails off before store
    wr(CODE_START_CFG, 8'h1A);
    snd(CODE_STORE_USER);
    nvwait();
    wr(CODE_START_CFG, 8'h1E); // stays off
    snd(CODE_RESTORE_USER);
    nvwait();
    rdchk(CODE_START_CFG, 8'h1A);
    rdchk(CODE_SECURITY, 8'h01);
    snd(CODE_RESTORE_FACT);
    rdchk(CODE_START_CFG, 8'h17);
    wr(CODE_START_CFG, 8'h1E);
    snd(CODE_STORE_DEFAULT);
    nvwait();
    snd(CODE_RESTORE_FACT);
    snd(CODE_RESTORE_DEF);
    nvwait();
    rdchk(CODE_START_CFG, 8'h1E);
    snd(CODE_RESTORE_FACT);
    snd(CODE_STORE_DEFAULT);
    nvwait();
    wr(CODE_START_CFG, 8'h18); // stays off
    snd(CODE_RESTORE_DEF);
    nvwait();
    rdchk(CODE_START_CFG, 8'h17);
    done_test("store restore");
    @(negedge clk) sysRst = 1'b1;
    repeat (10) @(negedge clk);
    sysRst = 1'b0;
    rdchk(CODE_START_CFG, 8'h17);
    rdchk(CODE_PAGE, 8'h00);
    done_test("power up load");
    finish_test();
  end
endmodule : pmbus_page_onoff_tb_top
